// *** rtl/dacr_chan_if.sv ***
/*
  Carrier between the serial port core and one channel's local slice.
  Assumes the core gates wr_stb with that channel's select bit.
*/
`timescale 1ns/1ps
interface dacr_chan_if;
  logic wr_stb; // Write to this channel, one cycle
  logic [12:0] addr; // Target offset
  logic [7:0] wdata; // Byte written
  logic commit; // Shadow to active transfer pulse
  logic sreset; // Soft reset pulse
  logic [7:0] power_rd; // Local power field, read view
  logic [7:0] shuffle_rd; // Local shuffle field, read view
  modport ctrl(output wr_stb, addr, wdata, commit, sreset,
               input power_rd, shuffle_rd);
  modport chan(input wr_stb, addr, wdata, commit, sreset,
               output power_rd, shuffle_rd);
endinterface : dacr_chan_if

// *** rtl/dacr_chan_regs.sv ***
/*
  One channel's local registers: power mode and shuffle, each with a
  shadow copy written by the host and an active copy used by the core.
  Assumes commit and sreset are single-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
module dacr_chan_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Core side
  dacr_chan_if.chan bus,
  // Active settings
  output logic [1:0] pwr_act_r,
  output logic [1:0] shuf_act_r
);
  logic [1:0] pwr_m_r; // Shadow power mode
  logic [1:0] shuf_m_r; // Shadow shuffle mode

  // ----------------------------------------------------------------
  // Shadow copies
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwr_m_r <= dacr_pkg::POWER_RST[1:0];
      shuf_m_r <= dacr_pkg::SHUFFLE_RST[1:0];
    end else if (bus.sreset) begin
      pwr_m_r <= dacr_pkg::POWER_RST[1:0];
      shuf_m_r <= dacr_pkg::SHUFFLE_RST[1:0];
    end else if (bus.wr_stb) begin
      // Only selected channels see the strobe
      if (bus.addr == dacr_pkg::ADDR_POWER) begin
        pwr_m_r <= bus.wdata[1:0];
      end
      if (bus.addr == dacr_pkg::ADDR_SHUFFLE) begin
        shuf_m_r <= bus.wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Active copies, moved only by a transfer or a soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwr_act_r <= dacr_pkg::POWER_RST[1:0];
      shuf_act_r <= dacr_pkg::SHUFFLE_RST[1:0];
    end else if (bus.sreset) begin
      pwr_act_r <= dacr_pkg::POWER_RST[1:0];
      shuf_act_r <= dacr_pkg::SHUFFLE_RST[1:0];
    end else if (bus.commit) begin
      pwr_act_r <= pwr_m_r;
      shuf_act_r <= shuf_m_r;
    end
  end

  // Read back the shadow, which is what the host last wrote
  assign bus.power_rd = {6'h00, pwr_m_r};
  assign bus.shuffle_rd = {6'h00, shuf_m_r};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_local_write;
    @(posedge clk_sys) disable iff (reset)
    bus.wr_stb && !bus.sreset && bus.addr == dacr_pkg::ADDR_POWER
      |=> pwr_m_r == $past(bus.wdata[1:0]);
  endproperty
  a_local_write: assert property (p_local_write)
    else $error("Local power write lost");

  property p_shadow_hold;
    @(posedge clk_sys) disable iff (reset)
    !bus.commit && !bus.sreset |=> $stable(pwr_act_r) && $stable(shuf_act_r);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("Active setting moved without transfer");

  property p_commit_copy;
    @(posedge clk_sys) disable iff (reset)
    bus.commit && !bus.sreset |=> shuf_act_r == $past(shuf_m_r);
  endproperty
  a_commit_copy: assert property (p_commit_copy)
    else $error("Transfer did not copy shuffle");

  c_commit: cover property (@(posedge clk_sys) bus.commit && pwr_m_r != 2'h0);
endmodule : dacr_chan_regs

// *** rtl/dacr_pkg.sv ***
/*
  Constants of the dual-channel converter configuration bank: register
  offsets, reset values, field positions and serial port FSM states.
  Assumes one system clock; serial pins are synchronised on clk_sys inside the bank.
*/
// Summary of operation
// - Unmapped addresses and bits do nothing; addresses read zero, spare setup bits 4:3 and select bits 7 and 3:2 read one
// - Setup register mirrors bit order, soft reset
// - Channel select bits pick local write targets
// - Bit 6 enables both output ports together
// - Transfer bit commits shadow copies to active
// - Local power mode: normal, full down, standby
// - Global bit picks external power-down pin action
// - Clock divide ratio is code plus one
// - Divider phase delays by coded input cycles
// - Local shuffle field, enabled after reset
// - Shadowed registers change nothing until transfer
// - Multi-select read returns channel A copy
// - Global registers ignore the channel bits, except setup, which needs both set
package dacr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_SETUP = 13'h000;
  localparam logic [12:0] ADDR_CHIP_IDENTIFIER = 13'h001;
  localparam logic [12:0] ADDR_CHAN_SEL = 13'h005;
  localparam logic [12:0] ADDR_POWER = 13'h008;
  localparam logic [12:0] ADDR_CLK_DIV = 13'h00b;
  localparam logic [12:0] ADDR_SHUFFLE = 13'h00c;
  localparam logic [12:0] ADDR_COMMIT = 13'h0ff;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_RST = 8'h18;
  localparam logic [7:0] CHAN_SEL_RST = 8'hcf;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [7:0] CLK_DIV_RST = 8'h00;
  localparam logic [7:0] SHUFFLE_RST = 8'h01;
  localparam logic [7:0] COMMIT_RST = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SETUP_LSB_HI = 6;
  localparam int SETUP_LSB_LO = 1;
  localparam int SETUP_SRST_HI = 5;
  localparam int SETUP_SRST_LO = 2;
  localparam int CHSEL_A = 0;
  localparam int CHSEL_B = 1;
  localparam int CHSEL_OUT_EN = 6;
  localparam int POWER_EXT_FN = 5;
  localparam int COMMIT_BIT = 0;
  // Power mode codes
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_FULL = 2'h1;
  localparam logic [1:0] PWR_STBY = 2'h2;
  // Frame counts and streaming length code
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  // Serial port FSM, Gray along idle-instr-data-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } dacr_state_t;
endpackage : dacr_pkg

// *** rtl/dacr_top.sv ***
/*
  Configuration bank of a dual-channel converter behind a three-wire
  serial port. Serial pins are asynchronous and are oversampled by
  clk_sys, which must run well above four times the serial clock.
*/
`timescale 1ns/1ps
module dacr_top #(
  parameter logic [7:0] CHIP_IDENTIFIER = 8'h5c // Arbitrary identifier value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial port pins
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n,
  // External power-down pin
  input wire logic pwrdn_pin,
  // Active settings
  output logic lsb_first,
  output logic out_port_en,
  output logic [2:0] clk_div_ratio,
  output logic [2:0] clk_div_phase,
  output logic [1:0] mode_a,
  output logic [1:0] mode_b,
  output logic [1:0] shuffle_a,
  output logic [1:0] shuffle_b
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_m, sclk_s, sclk_d, cs_m, cs_s, di_m, di_s, pd_m, pd_s;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
      {cs_m, cs_s} <= 2'h3; // Deselected
      {di_m, di_s, pd_m, pd_s} <= 4'h0;
    end else begin
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s; // Edge detect compares the second stage with this delayed copy
      cs_m <= port_select_n;
      cs_s <= cs_m;
      di_m <= sdio_i;
      di_s <= di_m;
      pd_m <= pwrdn_pin;
      pd_s <= pd_m;
    end
  end
  logic rise, fall;
  assign rise = sclk_s & ~sclk_d & ~cs_s;
  assign fall = ~sclk_s & sclk_d & ~cs_s;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  dacr_pkg::dacr_state_t state_r;
  logic [3:0] cnt_r; // Bit within instruction or byte
  logic [15:0] in_sr_r; // Incoming shift register
  logic rd_r; // Frame is a read
  logic [1:0] len_r, bytes_r; // Length code, bytes due after the current one
  logic [12:0] addr_r; // Current offset
  logic [7:0] out_sr_r; // Outgoing byte
  logic [15:0] sr_nxt;
  logic [7:0] byte_in;
  logic [12:0] addr_nxt, look_addr;
  logic [7:0] rd_data;
  logic wr_stb, byte_end, instr_end;

  // Bit order flips the shift direction, so the word layout is fixed
  assign sr_nxt = lsb_first ? {di_s, in_sr_r[15:1]} : {in_sr_r[14:0], di_s};
  assign byte_in = lsb_first ? sr_nxt[15:8] : sr_nxt[7:0];
  assign instr_end = rise && state_r == dacr_pkg::ST_INSTR
                     && cnt_r == dacr_pkg::INSTR_LAST;
  assign byte_end = rise && state_r == dacr_pkg::ST_DATA
                    && cnt_r == dacr_pkg::BYTE_LAST;
  assign wr_stb = byte_end && !rd_r;
  // Address walks up in LSB-first mode and down otherwise
  assign addr_nxt = lsb_first ? addr_r + 13'h0001 : addr_r - 13'h0001;
  assign look_addr = instr_end ? sr_nxt[12:0] : addr_nxt;

  // FSM, counters and address
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= dacr_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      in_sr_r <= 16'h0000;
      {rd_r, len_r, bytes_r} <= 5'h00;
      addr_r <= 13'h0000;
    end else if (cs_s) begin
      state_r <= dacr_pkg::ST_IDLE; // Deselect ends any frame
      cnt_r <= 4'h0;
    end else begin
      if (rise) begin
        in_sr_r <= sr_nxt;
        cnt_r <= cnt_r + 4'h1;
      end
      case (state_r)
        dacr_pkg::ST_IDLE: begin
          state_r <= dacr_pkg::ST_INSTR;
        end
        dacr_pkg::ST_INSTR: begin
          if (instr_end) begin
            state_r <= dacr_pkg::ST_DATA;
            cnt_r <= 4'h0;
            rd_r <= sr_nxt[15];
            len_r <= sr_nxt[14:13];
            bytes_r <= sr_nxt[14:13];
            addr_r <= sr_nxt[12:0];
          end
        end
        dacr_pkg::ST_DATA: begin
          if (byte_end) begin
            cnt_r <= 4'h0;
            addr_r <= addr_nxt;
            if (len_r != dacr_pkg::LEN_STREAM && bytes_r == 2'h0) begin
              state_r <= dacr_pkg::ST_DONE;
            end else begin
              bytes_r <= bytes_r - 2'h1;
            end
          end
        end
        dacr_pkg::ST_DONE: begin
          cnt_r <= 4'h0; // Extra clocks are ignored until deselect
        end
        default: begin
          state_r <= dacr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic srst_r, commit_r, chan_a_r, chan_b_r, out_en_r;
  logic pd_fn_m_r, pd_fn_r;
  logic [5:0] div_m_r, div_r;
  logic chan_all;
  assign chan_all = chan_a_r & chan_b_r;

  // Setup register: mirrored nibbles, accepted with both channels set
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lsb_first <= dacr_pkg::SETUP_RST[dacr_pkg::SETUP_LSB_HI];
      srst_r <= 1'b0;
    end else if (srst_r) begin
      lsb_first <= dacr_pkg::SETUP_RST[dacr_pkg::SETUP_LSB_HI];
      srst_r <= 1'b0; // Self-clearing
    end else if (wr_stb && addr_r == dacr_pkg::ADDR_SETUP && chan_all) begin
      // Either mirror copy is honoured
      lsb_first <= byte_in[dacr_pkg::SETUP_LSB_HI]
                   | byte_in[dacr_pkg::SETUP_LSB_LO];
      srst_r <= byte_in[dacr_pkg::SETUP_SRST_HI]
                | byte_in[dacr_pkg::SETUP_SRST_LO];
    end
  end

  // Channel select and transfer strobe; neither is shadowed
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      chan_a_r <= dacr_pkg::CHAN_SEL_RST[dacr_pkg::CHSEL_A];
      chan_b_r <= dacr_pkg::CHAN_SEL_RST[dacr_pkg::CHSEL_B];
      out_en_r <= dacr_pkg::CHAN_SEL_RST[dacr_pkg::CHSEL_OUT_EN];
      commit_r <= dacr_pkg::COMMIT_RST[dacr_pkg::COMMIT_BIT];
    end else if (srst_r) begin
      chan_a_r <= dacr_pkg::CHAN_SEL_RST[dacr_pkg::CHSEL_A];
      chan_b_r <= dacr_pkg::CHAN_SEL_RST[dacr_pkg::CHSEL_B];
      out_en_r <= dacr_pkg::CHAN_SEL_RST[dacr_pkg::CHSEL_OUT_EN];
      commit_r <= 1'b0;
    end else begin
      commit_r <= 1'b0; // Transfer bit clears itself
      if (wr_stb && addr_r == dacr_pkg::ADDR_CHAN_SEL) begin
        chan_a_r <= byte_in[dacr_pkg::CHSEL_A];
        chan_b_r <= byte_in[dacr_pkg::CHSEL_B];
        out_en_r <= byte_in[dacr_pkg::CHSEL_OUT_EN];
      end
      if (wr_stb && addr_r == dacr_pkg::ADDR_COMMIT) begin
        commit_r <= byte_in[dacr_pkg::COMMIT_BIT];
      end
    end
  end
  assign out_port_en = out_en_r; // One bit for both ports

  // Global shadowed fields; channel bits play no part
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pd_fn_m_r <= dacr_pkg::POWER_RST[dacr_pkg::POWER_EXT_FN];
      pd_fn_r <= dacr_pkg::POWER_RST[dacr_pkg::POWER_EXT_FN];
      div_m_r <= dacr_pkg::CLK_DIV_RST[5:0];
      div_r <= dacr_pkg::CLK_DIV_RST[5:0];
    end else if (srst_r) begin
      pd_fn_m_r <= dacr_pkg::POWER_RST[dacr_pkg::POWER_EXT_FN];
      pd_fn_r <= dacr_pkg::POWER_RST[dacr_pkg::POWER_EXT_FN];
      div_m_r <= dacr_pkg::CLK_DIV_RST[5:0];
      div_r <= dacr_pkg::CLK_DIV_RST[5:0];
    end else begin
      if (wr_stb && addr_r == dacr_pkg::ADDR_POWER) begin
        pd_fn_m_r <= byte_in[dacr_pkg::POWER_EXT_FN];
      end
      if (wr_stb && addr_r == dacr_pkg::ADDR_CLK_DIV) begin
        div_m_r <= byte_in[5:0];
      end
      if (commit_r) begin
        pd_fn_r <= pd_fn_m_r;
        div_r <= div_m_r;
      end
    end
  end
  // Divide by code plus one; phase in input clock cycles
  assign clk_div_ratio = div_r[2:0];
  assign clk_div_phase = div_r[5:3];

  // ----------------------------------------------------------------
  // Channel slices
  // ----------------------------------------------------------------
  dacr_chan_if if_a();
  dacr_chan_if if_b();
  logic [1:0] pwr_a, pwr_b;
  assign if_a.wr_stb = wr_stb && chan_a_r;
  assign if_b.wr_stb = wr_stb && chan_b_r;
  assign {if_a.addr, if_b.addr} = {addr_r, addr_r};
  assign {if_a.wdata, if_b.wdata} = {byte_in, byte_in};
  assign {if_a.commit, if_b.commit} = {commit_r, commit_r};
  assign {if_a.sreset, if_b.sreset} = {srst_r, srst_r};
  dacr_chan_regs u_chan_a (.clk_sys(clk_sys), .reset(reset), .bus(if_a),
    .pwr_act_r(pwr_a), .shuf_act_r(shuffle_a));
  dacr_chan_regs u_chan_b (.clk_sys(clk_sys), .reset(reset), .bus(if_b),
    .pwr_act_r(pwr_b), .shuf_act_r(shuffle_b));

  // Power-down pin overrides the local mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_a <= dacr_pkg::PWR_NORMAL;
      mode_b <= dacr_pkg::PWR_NORMAL;
    end else begin
      mode_a <= pd_s ? (pd_fn_r ? dacr_pkg::PWR_STBY : dacr_pkg::PWR_FULL)
                     : pwr_a;
      mode_b <= pd_s ? (pd_fn_r ? dacr_pkg::PWR_STBY : dacr_pkg::PWR_FULL)
                     : pwr_b;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic sel_a;
  assign sel_a = chan_a_r | ~chan_b_r; // A wins when both set
  always_comb begin
    case (look_addr)
      dacr_pkg::ADDR_SETUP: rd_data = {1'b0, lsb_first, 1'b0, 2'h3,
                                       1'b0, lsb_first, 1'b0};
      dacr_pkg::ADDR_CHIP_IDENTIFIER: rd_data = CHIP_IDENTIFIER;
      dacr_pkg::ADDR_CHAN_SEL: rd_data = {1'b1, out_en_r, 2'h0, 2'h3,
                                          chan_b_r, chan_a_r};
      dacr_pkg::ADDR_POWER: rd_data = {2'h0, pd_fn_m_r, 5'h00}
        | (sel_a ? if_a.power_rd : if_b.power_rd);
      dacr_pkg::ADDR_CLK_DIV: rd_data = {2'h0, div_m_r};
      dacr_pkg::ADDR_SHUFFLE: rd_data = sel_a ? if_a.shuffle_rd
                                              : if_b.shuffle_rd;
      dacr_pkg::ADDR_COMMIT: rd_data = {7'h00, commit_r};
      default: rd_data = 8'h00; // Unmapped reads as zero
    endcase
  end

  // Out bits change on falling serial edges; pin driven only in reads
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_sr_r <= 8'h00;
      sdio_o <= 1'b0;
      sdio_oe_n <= 1'b1;
    end else if (cs_s) begin
      sdio_oe_n <= 1'b1;
    end else if ((instr_end && sr_nxt[15]) || (byte_end && rd_r)) begin
      out_sr_r <= rd_data;
    end else if (fall && state_r == dacr_pkg::ST_DATA && rd_r) begin
      sdio_o <= lsb_first ? out_sr_r[0] : out_sr_r[7];
      out_sr_r <= lsb_first ? {1'b0, out_sr_r[7:1]} : {out_sr_r[6:0], 1'b0};
      sdio_oe_n <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_setup_mirror;
    @(posedge clk_sys) disable iff (reset)
    wr_stb && chan_all && addr_r == dacr_pkg::ADDR_SETUP && byte_in[1]
      && !srst_r |=> lsb_first;
  endproperty
  a_setup_mirror: assert property (p_setup_mirror)
    else $error("Low mirror bit did not set bit order");

  property p_srst_defaults;
    @(posedge clk_sys) disable iff (reset)
    srst_r |=> !srst_r && chan_a_r && chan_b_r && out_en_r && !lsb_first;
  endproperty
  a_srst_defaults: assert property (p_srst_defaults)
    else $error("Soft reset did not restore defaults");

  property p_commit_once;
    @(posedge clk_sys) disable iff (reset)
    commit_r |=> !commit_r;
  endproperty
  a_commit_once: assert property (p_commit_once)
    else $error("Transfer bit did not clear");

  property p_div_commit;
    @(posedge clk_sys) disable iff (reset)
    commit_r && !srst_r |=> div_r == $past(div_m_r);
  endproperty
  a_div_commit: assert property (p_div_commit)
    else $error("Divider not committed");

  property p_ext_pd;
    @(posedge clk_sys) disable iff (reset)
    pd_s && !pd_fn_r |=> mode_a == dacr_pkg::PWR_FULL
                         && mode_b == dacr_pkg::PWR_FULL;
  endproperty
  a_ext_pd: assert property (p_ext_pd)
    else $error("Pin power-down not forced");

  property p_unmapped;
    @(posedge clk_sys) disable iff (reset)
    look_addr == 13'h0002 |-> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped address read nonzero");

  c_read: cover property (@(posedge clk_sys) !sdio_oe_n);
  c_stream: cover property (@(posedge clk_sys) byte_end
                            && len_r == dacr_pkg::LEN_STREAM);
  c_srst: cover property (@(posedge clk_sys) srst_r);
endmodule : dacr_top

// *** tb/dacr_host.sv ***
/*
  Serial host model driving the three-wire port of the config bank.
  Assumes the bench resolves the data wire and feeds it back as sdio_w.
*/
`timescale 1ns/1ps
module dacr_host (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic sclk,
  output logic port_select_n,
  output logic sdio_h,
  input wire logic sdio_w
);
  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  initial begin
    sclk = 1'b0; // Stands still between frames
    port_select_n = 1'b1;
    sdio_h = 1'b0;
  end

  // Idle cycles; pins always move 1 ns after the edge
  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : gap

  // One frame of one or two bytes; byte 0 travels in wd[15:8] and q[15:8]
  // LSB mode reverses the instruction word and each data byte; length 00 means one byte
  task automatic frame(input bit lsb, input bit rd, input logic [1:0] ln,
                       input logic [12:0] a, input logic [15:0] wd,
                       output logic [15:0] q);
    logic [31:0] w;
    int nb;
    int b;
    w = {rd, ln, a, wd};
    nb = (ln == 2'b00) ? 1 : 2;
    q = 16'h0000;
    port_select_n = 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      // Bit of w sent in this slot, for either order
      b = (i < 16) ? 16 + i : 8 * (1 - (i - 16) / 8) + (i - 16) % 8;
      if (!lsb) b = 31 - i;
      // Released line toggles so no stale value can pass for data
      sdio_h = (rd && i >= 16) ? ~sdio_h : w[b];
      gap(8);
      sclk = 1'b1;
      if (i >= 16) begin
        q[b] = sdio_w;
      end
      gap(8);
      sclk = 1'b0;
    end
    gap(4);
    port_select_n = 1'b1;
    gap(6);
  endtask : frame
endmodule : dacr_host

// *** tb/tb.sv ***
/*
  Self-checking bench for the config bank against an integer model.
  Assumes dacr_host owns the serial pins and the bench owns the wire.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] CID = 8'h3e; // Arbitrary identifier value
  logic clk_sys, reset, pwrdn_pin, sclk, cs_n, sdio_h, sdio_o, sdio_oe_n;
  logic lsb_first, out_port_en;
  logic [2:0] ratio, phase;
  logic [1:0] mode_a, mode_b, shuf_a, shuf_b;
  wire sdio_w = sdio_oe_n ? sdio_h : sdio_o; // Resolved data wire
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h0f9f;
  // Model state
  int sel, en, lsb, ext_sh, ext_act, div_sh, div_act;
  int pw_sh[2], pw_act[2], sh_sh[2], sh_act[2];
  logic [15:0] q;
  logic [12:0] ra[8] = '{13'h000, 13'h001, 13'h005, 13'h008,
                         13'h00b, 13'h00c, 13'h0ff, 13'h013};

  dacr_top #(.CHIP_IDENTIFIER(CID)) dut (.clk_sys(clk_sys), .reset(reset),
    .sclk(sclk), .port_select_n(cs_n), .sdio_i(sdio_w), .sdio_o(sdio_o),
    .sdio_oe_n(sdio_oe_n), .pwrdn_pin(pwrdn_pin), .lsb_first(lsb_first),
    .out_port_en(out_port_en), .clk_div_ratio(ratio),
    .clk_div_phase(phase), .mode_a(mode_a), .mode_b(mode_b),
    .shuffle_a(shuf_a), .shuffle_b(shuf_b));
  dacr_host host (.clk_sys(clk_sys), .sclk(sclk), .port_select_n(cs_n),
    .sdio_h(sdio_h), .sdio_w(sdio_w));

  // ------------------------------------------------------------
  // Clock, model and checks
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic mreset();
    sel = 3;
    en = 1;
    lsb = 0;
    ext_sh = 0;
    ext_act = 0;
    div_sh = 0;
    div_act = 0;
    pw_sh = '{0, 0};
    pw_act = '{0, 0};
    sh_sh = '{1, 1};
    sh_act = '{1, 1};
  endtask : mreset

  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : cmp

  // Model side of one byte landing at one offset
  task automatic mdl(input logic [12:0] a, input logic [7:0] d);
    if (a == 13'h000 && sel == 3) begin
      if (d[5] | d[2]) mreset();
      else lsb = d[6] | d[1]; // Either mirror copy counts
    end
    if (a == 13'h005) begin
      en = d[6];
      sel = d[1:0];
    end
    if (a == 13'h008) ext_sh = d[5];
    if (a == 13'h00b) div_sh = d[5:0];
    for (int c = 0; c < 2; c++) begin
      if (sel[c] && a == 13'h008) pw_sh[c] = d[1:0];
      if (sel[c] && a == 13'h00c) sh_sh[c] = d[1:0];
    end
    if (a == 13'h0ff && d[0]) begin
      ext_act = ext_sh;
      div_act = div_sh;
      pw_act = pw_sh;
      sh_act = sh_sh;
    end
  endtask : mdl

  // Write a byte and mirror it into the model
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.frame(lsb[0], 1'b0, 2'b00, a, {d, 8'h00}, q);
    mdl(a, d);
  endtask : wr

  // Two bytes in one frame; the offset steps with the bit order
  task automatic wr2(input logic [1:0] ln, input logic [12:0] a,
                     input logic [15:0] d);
    logic [12:0] a2;
    a2 = lsb ? a + 13'h0001 : a - 13'h0001;
    host.frame(lsb[0], 1'b0, ln, a, d, q);
    mdl(a, d[15:8]);
    mdl(a2, d[7:0]);
  endtask : wr2

  // Expected read value of one offset
  function automatic logic [7:0] expd(input logic [12:0] a);
    int c;
    c = (sel[0] || !sel[1]) ? 0 : 1; // A unless only B is selected
    case (a)
      13'h000: return lsb ? 8'h5a : 8'h18;
      13'h001: return CID;
      13'h005: return 8'h8c | 8'(en << 6) | 8'(sel);
      13'h008: return 8'((ext_sh << 5) | pw_sh[c]);
      13'h00b: return 8'(div_sh);
      13'h00c: return 8'(sh_sh[c]);
      default: return 8'h00;
    endcase
  endfunction : expd

  task automatic rd(input logic [12:0] a);
    host.frame(lsb[0], 1'b1, 2'b00, a, 16'h0000, q);
    cmp($sformatf("read %h", a), expd(a), q[15:8]);
  endtask : rd

  // Two bytes read in one frame, the second at the stepped offset
  task automatic rd2(input logic [1:0] ln, input logic [12:0] a);
    logic [12:0] a2;
    a2 = lsb ? a + 13'h0001 : a - 13'h0001;
    host.frame(lsb[0], 1'b1, ln, a, 16'h0000, q);
    cmp($sformatf("read %h", a), expd(a), q[15:8]);
    cmp($sformatf("read %h", a2), expd(a2), q[7:0]);
  endtask : rd2

  task automatic chk();
    int m[2];
    for (int c = 0; c < 2; c++) m[c] = pwrdn_pin ? 1 + ext_act : pw_act[c];
    cmp("lsb_first", 8'(lsb), {7'h00, lsb_first});
    cmp("out_port_en", 8'(en), {7'h00, out_port_en});
    cmp("clk_div_ratio", 8'(div_act & 7), {5'h00, ratio});
    cmp("clk_div_phase", 8'(div_act >> 3), {5'h00, phase});
    cmp("mode_a", 8'(m[0]), {6'h00, mode_a});
    cmp("mode_b", 8'(m[1]), {6'h00, mode_b});
    cmp("shuffle_a", 8'(sh_act[0]), {6'h00, shuf_a});
    cmp("shuffle_b", 8'(sh_act[1]), {6'h00, shuf_b});
  endtask : chk

  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    pwrdn_pin = 1'b0;
    mreset();
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    host.gap(4);
    chk();
    wr(13'h001, 8'ha5);
    wr(13'h013, 8'h5a);
    foreach (ra[i]) rd(ra[i]);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr(13'h00b, {2'b00, seed[5:0]});
      chk();
      rd(13'h00b);
      wr(13'h0ff, 8'h01);
      chk();
      rd(13'h0ff);
    end
    seed = lfsr(seed);
    wr2(2'b11, 13'h00c, {8'h01, 2'b00, seed[5:0]});
    rd2(2'b01, 13'h00c);
    wr(13'h005, 8'h01);
    chk();
    wr(13'h008, 8'h01);
    wr(13'h00c, 8'h00);
    wr(13'h005, 8'h42);
    wr(13'h008, 8'h22);
    rd(13'h008);
    wr(13'h005, 8'h43);
    rd(13'h008);
    rd(13'h00c);
    chk();
    wr(13'h0ff, 8'h01);
    chk();
    pwrdn_pin = 1'b1;
    host.gap(6);
    chk();
    wr(13'h008, 8'h00);
    wr(13'h0ff, 8'h01);
    chk();
    pwrdn_pin = 1'b0;
    wr(13'h005, 8'h41);
    wr(13'h000, 8'h42);
    chk();
    wr(13'h005, 8'h43);
    wr(13'h000, 8'h42);
    chk();
    rd(13'h000);
    wr2(2'b01, 13'h00b, 16'h1501);
    wr(13'h0ff, 8'h01);
    rd(13'h00b);
    rd2(2'b11, 13'h00b);
    chk();
    wr(13'h000, 8'h24);
    host.gap(4);
    chk();
    foreach (ra[i]) rd(ra[i]);
    end_sim();
  end
endmodule : tb
